// ### logic/dpm_consts.svh
// Offsets, field positions, reset values and timing counts of the port host
`ifndef DPM_CONSTS_SVH
`define DPM_CONSTS_SVH

// Register byte offsets on APB
`define DPM_REG_CTRL      8'h00
`define DPM_REG_ADDR      8'h04
`define DPM_REG_WDATA     8'h08
`define DPM_REG_RDATA     8'h0C
`define DPM_REG_STATUS    8'h10

// CTRL fields
`define DPM_CTRL_START    0
`define DPM_CTRL_OP_LO    1
`define DPM_CTRL_OP_HI    3
`define DPM_CTRL_SIDE     4
`define DPM_CTRL_BLOCK    5
`define DPM_CTRL_RST      6'h00

// STATUS fields
`define DPM_ST_BUSY       0
`define DPM_ST_DONE       1
`define DPM_ST_LOST       2
`define DPM_ST_MBX        3
`define DPM_ST_CONT       4
`define DPM_ST_INIT       5

// Mailbox word addresses
`define DPM_MBX_LEFT      13'h1FFE
`define DPM_MBX_RIGHT     13'h1FFF

// Device access time in ns and clock period in ns
`define DPM_ACC_NS        70
`define DPM_CLK_NS        50
// Least time: round up; two more cycles cover the data synchroniser
`define DPM_ACC_CYC       ((`DPM_ACC_NS + `DPM_CLK_NS - 1) / `DPM_CLK_NS)
`define DPM_STROBE_CYC    (`DPM_ACC_CYC + 2)

`endif

// ### logic/dpm_host.sv
// Host controller driving one port of a dual-port memory with mailbox
//
// The register addresses and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`include "dpm_consts.svh"
module dpm_host (
    // Clock and reset
    input  wire logic             CLK,
    input  wire logic             RESET_N,
    // APB slave
    input  wire logic [7:0]       PADDR,
    input  wire logic             PSEL,
    input  wire logic             PENABLE,
    input  wire logic             PWRITE,
    input  wire logic [31:0]      PWDATA,
    output logic      [31:0]      PRDATA,
    output logic                  PREADY,
    output logic                  PSLVERR,
    // Device port control
    output dpm_pkg::dpm_pins_t    PINS,
    // Device port data, two-way
    input  wire logic [15:0]      DQ_I,
    output logic      [15:0]      DQ_O,
    output logic                  DQ_OE_N,
    // Device flags and contention
    input  wire logic             MBX_FLAG_N,
    input  wire logic             CONT_A_N,
    input  wire logic             CONT_B_N,
    output logic                  CONT_DRV_N
);
    import dpm_pkg::*;

    dpm_state_t  state_ff;
    dpm_op_t     op_ff;
    dpm_pins_t   pins_ff;
    logic [2:0]  cnt_ff;
    logic [15:0] dq_o_ff;
    logic        dq_oe_n_ff;
    logic        side_ff;
    logic        block_ff;
    logic [2:0]  op_reg_ff;
    logic [12:0] addr_reg_ff;
    logic [15:0] wdata_ff;
    logic [15:0] rdata_ff;
    logic        done_ff;
    logic        lost_ff;
    logic        init_pend_ff;
    logic [31:0] prdata_ff;
    logic        pslverr_ff;
    logic [2:0]  flags_s;
    logic [15:0] dq_s;
    logic        cont_s;
    logic        start;
    logic        go;
    logic        go_side;
    dpm_op_t     go_op;
    logic        go_sem;
    logic        go_wr;
    logic [12:0] go_addr;
    logic [12:0] own_mbx;
    logic [12:0] far_mbx;
    logic        op_wr;
    logic        apb_wr;
    logic        apb_setup;
    logic        mapped;

    // Flags and contention lines arrive from pins
    dpm_sync #(.W(3), .RST(16'hFFFF)) u_sync_flags (
        .clk     (CLK),
        .reset_n (RESET_N),
        .d       ({CONT_A_N, CONT_B_N, MBX_FLAG_N}),
        .q       (flags_s)
    );

    dpm_sync #(.W(16), .RST(16'h0000)) u_sync_dq (
        .clk     (CLK),
        .reset_n (RESET_N),
        .d       (DQ_I),
        .q       (dq_s)
    );

    // Array-level contention of stacked devices
    assign cont_s = flags_s[2] & flags_s[1];
    // Own mailbox clears our flag; side rides on the START write itself
    assign go_side = (start && !init_pend_ff) ? PWDATA[`DPM_CTRL_SIDE] :
                     side_ff;
    assign own_mbx = go_side ? `DPM_MBX_RIGHT : `DPM_MBX_LEFT;
    assign far_mbx = go_side ? `DPM_MBX_LEFT : `DPM_MBX_RIGHT;
    assign apb_setup = PSEL && !PENABLE;
    assign apb_wr    = PSEL && PENABLE && PWRITE;
    assign mapped    = (PADDR == `DPM_REG_CTRL) || (PADDR == `DPM_REG_ADDR) ||
                       (PADDR == `DPM_REG_WDATA) ||
                       (PADDR == `DPM_REG_RDATA) ||
                       (PADDR == `DPM_REG_STATUS);
    assign start     = apb_wr && (PADDR == `DPM_REG_CTRL) &&
                       PWDATA[`DPM_CTRL_START];

    // Power-up take of our own mailbox has priority over software
    assign go    = (state_ff == S_IDLE) && (init_pend_ff || start);
    assign go_op = init_pend_ff ? OP_TAKE :
                   dpm_op_t'(PWDATA[`DPM_CTRL_OP_HI:`DPM_CTRL_OP_LO]);
    always_comb begin
        go_sem  = (go_op == OP_SRD) || (go_op == OP_SWR);
        go_wr   = (go_op == OP_MWR) || (go_op == OP_SWR) ||
                  (go_op == OP_POST);
        go_addr = addr_reg_ff;
        if (go_op == OP_POST) begin
            go_addr = far_mbx;
        end else if (go_op == OP_TAKE) begin
            go_addr = own_mbx;
        end
    end
    assign op_wr = (op_ff == OP_MWR) || (op_ff == OP_SWR) ||
                   (op_ff == OP_POST);
    // Access sequencer and pin drive
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            state_ff   <= S_IDLE;
            op_ff      <= OP_MRD;
            cnt_ff     <= 3'h0;
            pins_ff    <= '{1'b1, 1'b1, 1'b1, 1'b1, 13'h0000};
            dq_o_ff    <= 16'h0000;
            dq_oe_n_ff <= 1'b1;
        end else begin
            unique case (state_ff)
                S_IDLE: begin
                    if (go) begin
                        op_ff <= go_op;
                        pins_ff.addr <= go_addr;
                        // Semaphore space: memory select stays high
                        pins_ff.mem_select_n       <= go_sem;
                        pins_ff.semaphore_select_n <= !go_sem;
                        dq_o_ff    <= wdata_ff;
                        dq_oe_n_ff <= !go_wr;
                        state_ff   <= S_SETUP;
                    end
                end
                S_SETUP: begin
                    pins_ff.output_enable_n <= op_wr;
                    pins_ff.read_write_n    <= !op_wr;
                    cnt_ff   <= 3'(`DPM_STROBE_CYC - 1);
                    state_ff <= S_STROBE;
                end
                S_STROBE: begin
                    if (cnt_ff == 3'h0) begin
                        pins_ff.output_enable_n <= 1'b1;
                        pins_ff.read_write_n    <= 1'b1;
                        state_ff <= S_REL;
                    end else begin
                        cnt_ff <= cnt_ff - 3'h1;
                    end
                end
                S_REL: begin
                    // Releasing select lets a semaphore re-read see news
                    pins_ff.mem_select_n       <= 1'b1;
                    pins_ff.semaphore_select_n <= 1'b1;
                    dq_oe_n_ff <= 1'b1;
                    state_ff   <= S_IDLE;
                end
            endcase
        end
    end

    // Software registers
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            op_reg_ff   <= 3'h0;
            side_ff     <= 1'b0;
            block_ff    <= 1'b0;
            addr_reg_ff <= 13'h0000;
            wdata_ff    <= 16'h0000;
        end else if (apb_wr) begin
            if (PADDR == `DPM_REG_CTRL) begin
                op_reg_ff <= PWDATA[`DPM_CTRL_OP_HI:`DPM_CTRL_OP_LO];
                side_ff   <= PWDATA[`DPM_CTRL_SIDE];
                block_ff  <= PWDATA[`DPM_CTRL_BLOCK];
            end
            if (PADDR == `DPM_REG_ADDR) begin
                addr_reg_ff <= PWDATA[12:0];
            end
            if (PADDR == `DPM_REG_WDATA) begin
                wdata_ff <= PWDATA[15:0];
            end
        end
    end

    // Completion status; a hardware set beats a same-cycle clear
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            done_ff      <= 1'b0;
            lost_ff      <= 1'b0;
            init_pend_ff <= 1'b1;
            rdata_ff     <= 16'h0000;
        end else begin
            if (go && init_pend_ff) begin
                init_pend_ff <= 1'b0;
            end
            if (state_ff == S_STROBE && cnt_ff == 3'h0 && !op_wr) begin
                rdata_ff <= dq_s;
            end
            if (state_ff == S_REL) begin
                done_ff <= 1'b1;
            end else if (apb_wr && PADDR == `DPM_REG_STATUS &&
                         PWDATA[`DPM_ST_DONE]) begin
                done_ff <= 1'b0;
            end
            // Device drops writes while contention is low
            if (state_ff == S_STROBE && op_wr && !cont_s) begin
                lost_ff <= 1'b1;
            end else if (apb_wr && PADDR == `DPM_REG_STATUS &&
                         PWDATA[`DPM_ST_LOST]) begin
                lost_ff <= 1'b0;
            end
        end
    end

    // APB read data captured in the setup phase, answered with no wait
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            prdata_ff  <= 32'h0000_0000;
            pslverr_ff <= 1'b0;
        end else if (apb_setup) begin
            pslverr_ff <= !mapped;
            prdata_ff  <= 32'h0000_0000;
            unique case (PADDR)
                `DPM_REG_CTRL:   prdata_ff[5:1] <= {block_ff, side_ff,
                                                    op_reg_ff};
                `DPM_REG_ADDR:   prdata_ff[12:0] <= addr_reg_ff;
                `DPM_REG_WDATA:  prdata_ff[15:0] <= wdata_ff;
                `DPM_REG_RDATA:  prdata_ff[15:0] <= rdata_ff;
                `DPM_REG_STATUS: prdata_ff[5:0] <= {!init_pend_ff, !cont_s,
                                                    !flags_s[0], lost_ff,
                                                    done_ff,
                                                    state_ff != S_IDLE};
                default:         prdata_ff <= 32'h0000_0000;
            endcase
        end
    end

    assign PRDATA     = prdata_ff;
    assign PREADY     = 1'b1;
    assign PSLVERR    = pslverr_ff && PSEL && PENABLE;
    assign PINS       = pins_ff;
    assign DQ_O       = dq_o_ff;
    assign DQ_OE_N    = dq_oe_n_ff;
    // Slave-mode write inhibit input: high for normal use
    assign CONT_DRV_N = !block_ff;

    sequence seq_strobe;
        (state_ff == S_STROBE) [*4] ##1 (state_ff == S_REL);
    endsequence
    a_mbx_init_take: assert property (@(posedge CLK) disable iff (!RESET_N)
        (state_ff == S_IDLE && init_pend_ff) |=>
        (state_ff == S_SETUP && pins_ff.addr == $past(own_mbx) &&
         op_ff == OP_TAKE))
        else $error("power-up mailbox take missing");
    a_sem_space_sel: assert property (@(posedge CLK) disable iff (!RESET_N)
        !PINS.semaphore_select_n |-> PINS.mem_select_n)
        else $error("semaphore select with memory select low");
    a_access_shape: assert property (@(posedge CLK) disable iff (!RESET_N)
        (state_ff == S_SETUP) |=> seq_strobe ##1
        (PINS.mem_select_n && PINS.semaphore_select_n))
        else $error("access strobe shape wrong");
    a_cont_drive: assert property (@(posedge CLK) disable iff (!RESET_N)
        $changed(CONT_DRV_N) |-> $past(apb_wr) &&
        $past(PADDR) == `DPM_REG_CTRL)
        else $error("contention drive changed without a write");
    a_cont_and: assert property (@(posedge CLK) disable iff (!RESET_N)
        $past(RESET_N, 3) |->
        cont_s == ($past(CONT_A_N, 2) & $past(CONT_B_N, 2)))
        else $error("combined contention mismatch");
endmodule

// ### logic/dpm_pkg.sv
// Types shared by the dual-port memory port host
package dpm_pkg;

    typedef enum logic [2:0] {
        OP_MRD  = 3'h0,
        OP_MWR  = 3'h1,
        OP_SRD  = 3'h2,
        OP_SWR  = 3'h3,
        OP_POST = 3'h4,
        OP_TAKE = 3'h5
    } dpm_op_t;

    typedef enum logic [1:0] {
        S_IDLE   = 2'h0,
        S_SETUP  = 2'h1,
        S_STROBE = 2'h2,
        S_REL    = 2'h3
    } dpm_state_t;

    // Control pins of one device port, all active low except addr
    typedef struct packed {
        logic        mem_select_n;
        logic        semaphore_select_n;
        logic        output_enable_n;
        logic        read_write_n;
        logic [12:0] addr;
    } dpm_pins_t;

endpackage

// ### logic/dpm_sync.sv
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module dpm_sync #(
    parameter int          W   = 1,
    parameter logic [15:0] RST = 16'hFFFF
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         reset_n,
    // Data
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_ff;

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            meta_ff <= RST[W-1:0];
            q       <= RST[W-1:0];
        end else begin
            meta_ff <= d;
            q       <= meta_ff;
        end
    end
endmodule

// ### testbench/dpm_dev_model.sv
// Behavioural model of the left port of the dual-port device
`timescale 1ns/1ps
module dpm_dev_model (
    // Host side pins
    input  wire dpm_pkg::dpm_pins_t pins,
    input  wire logic [15:0]        dq_o,
    input  wire logic               dq_oe_n,
    input  wire logic               busy_n,
    // Wire level and flags
    output logic      [15:0]        dq_i,
    output logic                    mbx_flag_n,
    output logic                    peer_flag_n,
    // Master-mode contention of both ports
    output logic                    cont_n,
    output logic                    peer_cont_n
);
    import dpm_pkg::*;
    logic [15:0] mem [int];
    logic        tok [2][8];
    logic        pend [2][8];
    logic [15:0] rd_v;
    logic [15:0] last_v;
    logic        peer_on;
    logic        later_l;
    logic [12:0] peer_a;
    wire sel     = !(pins.mem_select_n && pins.semaphore_select_n);
    wire rd_on   = sel && !pins.output_enable_n;
    wire wr_on   = sel && !pins.read_write_n;
    // The port whose select and address settled later sees contention
    wire match   = !pins.mem_select_n && peer_on && pins.addr == peer_a;
    assign cont_n      = !(match && later_l);
    assign peer_cont_n = !(match && !later_l);
    wire mbx_hit = !pins.mem_select_n && busy_n && cont_n;
    task automatic peer_select(input logic [12:0] ad);
        peer_a = ad;
        later_l = 1'h0;
        peer_on = 1'h1;
    endtask
    task automatic peer_release();
        peer_on = 1'h0;
    endtask
    always @(negedge pins.mem_select_n) later_l = peer_on;
    task automatic sem_wr(input int s, input int i, input logic b);
        if (!b && tok[1-s][i]) pend[s][i] = 1'h1;
        else if (!b) tok[s][i] = 1'h1;
        else if (tok[s][i]) begin
            tok[s][i] = 1'h0;
            tok[1-s][i] = pend[1-s][i];
            pend[1-s][i] = 1'h0;
        end else pend[s][i] = 1'h0;
    endtask
    task automatic peer_post();
        mbx_flag_n = 1'h0;
    endtask
    task automatic peer_take();
        peer_flag_n = 1'h1;
    endtask
    task automatic peer_sem(input int i, input logic b);
        sem_wr(1, i, b);
    endtask
    // Flags come up set, since power-up leaves them undefined
    initial begin
        mbx_flag_n = 1'h0;
        peer_flag_n = 1'h0;
        tok = '{default: 1'h0};
        pend = '{default: 1'h0};
        peer_on = 1'h0;
        later_l = 1'h0;
        peer_a = 13'h0;
    end
    // Value frozen while select and enable stay active
    always @(posedge rd_on) begin
        if (!pins.semaphore_select_n)
            rd_v = {16{!tok[0][pins.addr[2:0]]}};
        else if (mem.exists(int'(pins.addr)))
            rd_v = mem[int'(pins.addr)];
        else
            rd_v = 16'h0;
        if (mbx_hit && pins.addr == 13'h1FFE) mbx_flag_n = 1'h1;
    end
    always @(posedge wr_on)
        if (mbx_hit && pins.addr == 13'h1FFF) peer_flag_n = 1'h0;
    // Data taken as the strobe ends; a low busy input drops it
    always @(negedge wr_on) begin
        if (busy_n && !pins.semaphore_select_n)
            sem_wr(0, pins.addr[2:0], dq_o[0]);
        else if (busy_n && cont_n)
            mem[int'(pins.addr)] = dq_o;
    end
    // Released bus shows the inverse of its last value
    always @* begin
        if (!dq_oe_n) last_v = dq_o;
        else if (rd_on) last_v = rd_v;
    end
    assign dq_i = !dq_oe_n ? dq_o : (rd_on ? rd_v : ~last_v);
endmodule

// ### testbench/dpm_host_bench.sv
// Self-checking bench for the dual-port memory port host
`timescale 1ns/1ps
`include "dpm_consts.svh"
module dpm_host_bench;
    import dpm_pkg::*;
    logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, blk;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, st, r;
    dpm_pins_t   pins;
    logic [15:0] dq_i, dq_o, d;
    logic        dq_oe_n, mbx_n, cont_a_n, cont_b_n, cont_drv_n, peer_n;
    logic        err, sd, dev_cont_n, peer_cont_n;
    // Board-level AND of the bench line and the model's master output
    wire         cont_a_w = cont_a_n & dev_cont_n;
    logic [12:0] a;
    logic [15:0] bmem [int];
    int          btok [2][8];
    int          bpend [2][8];
    int          errors, n_compared, cyc;
    logic [1:0]  seq [8] = '{2'h0, 2'h2, 2'h1, 2'h0, 2'h3, 2'h1, 2'h2, 2'h3};

    dpm_host dut_u (.CLK(clk), .RESET_N(rst_n), .PADDR(paddr), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PWDATA(pwdata), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .PINS(pins), .DQ_I(dq_i),
        .DQ_O(dq_o), .DQ_OE_N(dq_oe_n), .MBX_FLAG_N(mbx_n),
        .CONT_A_N(cont_a_w), .CONT_B_N(cont_b_n), .CONT_DRV_N(cont_drv_n));
    dpm_dev_model dev_u (.pins(pins), .dq_o(dq_o), .dq_oe_n(dq_oe_n),
        .busy_n(cont_drv_n), .dq_i(dq_i), .mbx_flag_n(mbx_n),
        .peer_flag_n(peer_n), .cont_n(dev_cont_n),
        .peer_cont_n(peer_cont_n));

    task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED t=%0t word %h exp %h", $time, got, exp);
        end
    endtask
    task automatic check_pin(input logic got, input logic exp);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED t=%0t pin %b exp %b", $time, got, exp);
        end
    endtask
    task automatic report_and_stop;
        $display("errors=%0d compared=%0d", errors, n_compared);
        if (errors == 0 && n_compared > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // One APB transfer, then an idle cycle
    task automatic apb(input logic w, input logic [7:0] ad,
                       input logic [31:0] wd, output logic [31:0] rd);
        psel <= 1'h1;
        paddr <= ad;
        pwrite <= w;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'h1;
        @(posedge clk);
        while (pready !== 1'h1) @(posedge clk);
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge clk);
    endtask
    task automatic poll(input int b);
        int n;
        n = 0;
        st = 32'h0;
        while (st[b] !== 1'h1 && n < 40) begin
            apb(1'h0, `DPM_REG_STATUS, 32'h0, st);
            n++;
        end
        if (st[b] !== 1'h1) begin
            errors++;
            $display("CHECK FAILED t=%0t status bit %0d never set", $time, b);
        end
    endtask
    task automatic do_op(input dpm_op_t op, input logic [12:0] ad,
                         input logic [15:0] wd, output logic [31:0] rd);
        apb(1'h1, `DPM_REG_ADDR, {19'h0, ad}, rd);
        apb(1'h1, `DPM_REG_WDATA, {16'h0, wd}, rd);
        apb(1'h1, `DPM_REG_CTRL, {26'h0, blk, sd, op, 1'h1}, rd);
        poll(1);
        apb(1'h0, `DPM_REG_RDATA, 32'h0, rd);
        apb(1'h1, `DPM_REG_STATUS, 32'h2, r);
    endtask
    // Expected token state, kept apart from the device model
    task automatic bsem(input int s, input int i, input int b);
        if (b == 0 && btok[1-s][i] == 1) bpend[s][i] = 1;
        else if (b == 0) btok[s][i] = 1;
        else if (btok[s][i] == 1) begin
            btok[s][i] = 0;
            btok[1-s][i] = bpend[1-s][i];
            bpend[1-s][i] = 0;
        end else bpend[s][i] = 0;
    endtask

    initial begin
        clk = 1'h0;
        forever #25 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 40000) begin
            errors++;
            report_and_stop();
        end
    end

    // The later port's contention never meets the other one low
    always @(negedge dev_cont_n) check_pin(peer_cont_n, 1'h1);

    initial begin
        {rst_n, psel, penable, pwrite, blk, sd} = 6'h0;
        {cont_a_n, cont_b_n} = 2'h3;
        paddr = 8'h0;
        pwdata = 32'h0;
        btok = '{default: 0};
        bpend = '{default: 0};
        void'($urandom(32'hE50A9224));
        repeat (3) @(posedge clk);
        rst_n <= 1'h1;
        @(posedge clk);
        poll(1);
        check_word(st & 32'h29, 32'h20);
        apb(1'h1, `DPM_REG_STATUS, 32'h2, r);
        apb(1'h0, 8'h40, 32'h0, r);
        check_pin(err, 1'h1);
        check_word(r, 32'h0);
        apb(1'h1, `DPM_REG_CTRL, 32'h20, r);
        apb(1'h0, `DPM_REG_CTRL, 32'h0, r);
        check_word(r, 32'h20);
        check_pin(cont_drv_n, 1'h0);
        apb(1'h1, `DPM_REG_CTRL, 32'h0, r);
        dev_u.peer_take();
        for (int k = 0; k < 8; k++) begin
            a = (k < 2) ? 13'h1FFE + 13'(k) : 13'($urandom);
            d = 16'($urandom);
            do_op(OP_MWR, a, d, r);
            bmem[int'(a)] = d;
        end
        foreach (bmem[k]) begin
            do_op(OP_MRD, 13'(k), 16'h0, r);
            check_word(r, {16'h0, bmem[k]});
        end
        check_pin(peer_n, 1'h0);
        d = 16'($urandom);
        do_op(OP_POST, 13'h0, d, r);
        do_op(OP_MRD, 13'h1FFF, 16'h0, r);
        check_word(r, {16'h0, d});
        dev_u.peer_post();
        repeat (3) @(posedge clk);
        apb(1'h0, `DPM_REG_STATUS, 32'h0, st);
        check_pin(st[3], 1'h1);
        do_op(OP_TAKE, 13'h0, 16'h0, r);
        check_word(r, {16'h0, bmem[13'h1FFE]});
        apb(1'h0, `DPM_REG_STATUS, 32'h0, st);
        check_pin(st[3], 1'h0);
        sd = 1'h1;
        do_op(OP_TAKE, 13'h0, 16'h0, r);
        check_word(r, {16'h0, d});
        d = 16'($urandom);
        do_op(OP_POST, 13'h0, d, r);
        sd = 1'h0;
        do_op(OP_MRD, 13'h1FFE, 16'h0, r);
        check_word(r, {16'h0, d});
        bmem[13'h1FFE] = d;
        blk = 1'h1;
        do_op(OP_MWR, 13'h1FFE, ~bmem[13'h1FFE], r);
        blk = 1'h0;
        do_op(OP_MRD, 13'h1FFE, 16'h0, r);
        check_word(r, {16'h0, bmem[13'h1FFE]});
        for (int i = 0; i < 8; i++) begin
            foreach (seq[j]) begin
                if (seq[j][1]) dev_u.peer_sem(i, seq[j][0]);
                else do_op(OP_SWR, 13'(i), {15'h0, seq[j][0]}, r);
                bsem(seq[j][1], i, seq[j][0]);
                do_op(OP_SRD, 13'(i), 16'h0, r);
                check_word(r, {16'h0, {16{btok[0][i] == 0}}});
            end
        end
        dev_u.peer_select(13'h0456);
        do_op(OP_MWR, 13'h0457, 16'h1234, r);
        bmem[32'h457] = 16'h1234;
        check_word(st & 32'h14, 32'h0);
        do_op(OP_MWR, 13'h0456, 16'hA5A5, r);
        check_word(st & 32'h4, 32'h4);
        check_pin(dev_cont_n, 1'h1);
        dev_u.peer_release();
        apb(1'h1, `DPM_REG_STATUS, 32'h4, r);
        do_op(OP_MRD, 13'h0456, 16'h0, r);
        d = bmem.exists(32'h456) ? bmem[32'h456] : 16'h0;
        check_word(r, {16'h0, d});
        cont_a_n <= 1'h0;
        do_op(OP_MWR, 13'h0123, 16'h5A5A, r);
        check_word(st & 32'h14, 32'h14);
        cont_a_n <= 1'h1;
        cont_b_n <= 1'h0;
        repeat (4) @(posedge clk);
        apb(1'h1, `DPM_REG_STATUS, 32'h4, r);
        apb(1'h0, `DPM_REG_STATUS, 32'h0, st);
        check_word(st & 32'h14, 32'h10);
        report_and_stop();
    end
endmodule
